// File: dv/adcfc_core_model.sv
/* converter core and dma channel seen from the control block
   assumes the bench commands one result per go cycle */
`timescale 1ns/1ps
`default_nettype none
module adcfc_core_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // bench commands
    input wire logic go,
    input wire logic [11:0] go_data,
    input wire logic [5:0] go_ch,
    input wire logic stall,
    // raw results
    output logic raw_valid,
    output logic [11:0] raw_data,
    output logic [5:0] raw_channel,
    // dma channel
    input wire logic dma_valid,
    output logic dma_ready,
    input wire logic [15:0] dma_data,
    input wire logic [15:0] dma_addr,
    output logic [15:0] rx_data,
    output logic [15:0] rx_addr,
    output logic [7:0] rx_cnt
);
    assign dma_ready = !stall;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            raw_valid <= 1'b0;
            raw_data <= 12'h000;
            raw_channel <= 6'h00;
            rx_data <= 16'h0000;
            rx_addr <= 16'h0000;
            rx_cnt <= 8'h00;
        end else begin
            raw_valid <= go;
            // stale lines flip so nothing reads an old result by luck
            raw_data <= go ? go_data : ~raw_data;
            raw_channel <= go ? go_ch : ~raw_channel;
            if (dma_valid && dma_ready) begin
                rx_data <= dma_data;
                rx_addr <= dma_addr;
                rx_cnt <= rx_cnt + 8'h01;
            end
        end
    end
endmodule // adcfc_core_model
`default_nettype wire

// File: dv/adcfc_ctrl_props.sv
/* assertions on the ports of the converter control block
   assumes one clock and a bind onto adcfc_ctrl */
`timescale 1ns/1ps
`default_nettype none
module adcfc_ctrl_props
    import adcfc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // converter side
    input wire logic device_idle,
    input wire logic conv_enable,
    input wire logic conv_12bit,
    input wire logic [2:0] conv_sh_count,
    // dma side
    input wire logic dma_valid,
    input wire logic dma_ready,
    input wire logic [15:0] dma_data,
    input wire logic [15:0] dma_addr
);
    // shadow of bits that every write takes
    logic on_r;
    logic halt_r;
    logic [1:0] fmt_r;
    wire ctrl_wr = reg_wr && (reg_addr == ADCFC_OFF_CTRL1);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            on_r <= 1'b0;
            halt_r <= 1'b0;
            fmt_r <= 2'h0;
        end else if (ctrl_wr) begin
            on_r <= reg_wdata[ADCFC_BIT_ON];
            halt_r <= reg_wdata[ADCFC_BIT_IDLE_HALT];
            fmt_r <= reg_wdata[ADCFC_BIT_FORM_HI:ADCFC_BIT_FORM_LO];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence run_s;
        (on_r && (!halt_r || !device_idle)) [*3];
    endsequence
    sequence halt_s;
        (on_r && halt_r && device_idle) [*3];
    endsequence
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not cleared");
    conv_off_a: assert property (!on_r [*2] |=> !conv_enable)
        else $error("converter runs while off");
    conv_run_a: assert property (run_s |=> conv_enable)
        else $error("converter not running");
    idle_halt_a: assert property (halt_s |=> !conv_enable)
        else $error("converter not halted in idle");
    sh_ten_a: assert property (!conv_12bit && !$past(rst) |-> conv_sh_count == 3'h4)
        else $error("sample hold count not four");
    sh_twelve_a: assert property (conv_12bit |-> conv_sh_count == 3'h1)
        else $error("sample hold count not one");
    property res_p(logic locked);
        logic v;
        (ctrl_wr && on_r == locked, v = locked ? conv_12bit : reg_wdata[ADCFC_BIT_RES])
            ##1 !reg_wr |=> conv_12bit == v;
    endproperty
    res_take_a: assert property (res_p(1'b0))
        else $error("resolution write not taken");
    res_lock_a: assert property (res_p(1'b1))
        else $error("resolution changed while on");
    result_hold_a: assert property (dma_valid && !dma_ready |=>
        dma_valid && $stable(dma_data) && $stable(dma_addr))
        else $error("dma output dropped before ready");
    fmt_int_a: assert property ($rose(dma_valid) && fmt_r == ADCFC_FMT_UINT |->
        dma_data[15:12] == 4'h0 && (conv_12bit || dma_data[11:10] == 2'h0))
        else $error("integer upper bits not zero");
    fmt_frac_a: assert property ($rose(dma_valid) && fmt_r[1] |->
        dma_data[3:0] == 4'h0 && (conv_12bit || dma_data[5:4] == 2'h0))
        else $error("fraction lower bits not zero");
endmodule // adcfc_ctrl_props
bind adcfc_ctrl adcfc_ctrl_props adcfc_ctrl_props_i (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .device_idle(device_idle), .conv_enable(conv_enable),
    .conv_12bit(conv_12bit), .conv_sh_count(conv_sh_count), .dma_valid(dma_valid),
    .dma_ready(dma_ready), .dma_data(dma_data), .dma_addr(dma_addr));
`default_nettype wire

// File: dv/adcfc_ctrl_tb.sv
/* self-checking bench for the converter control block
   assumes the core model drives raw results and sinks dma words */
`timescale 1ns/1ps
`default_nettype none
module adcfc_ctrl_tb;
    import adcfc_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic device_idle = 1'b0, go = 1'b0, stall = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [11:0] go_data = 12'h000;
    logic [5:0] go_ch = 6'h00;
    wire logic conv_enable, conv_12bit, raw_valid, dma_valid, dma_ready;
    wire logic [2:0] conv_sh_count;
    wire logic [11:0] raw_data;
    wire logic [5:0] raw_channel;
    wire logic [15:0] reg_rdata, dma_data, dma_addr, rx_data, rx_addr;
    wire logic [7:0] rx_cnt;
    int mismatches = 0, check_count = 0;
    always #50 sys_clk = ~sys_clk;
    adcfc_ctrl adcfc_ctrl_i (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .device_idle(device_idle), .conv_enable(conv_enable), .conv_12bit(conv_12bit),
        .conv_sh_count(conv_sh_count), .raw_valid(raw_valid), .raw_data(raw_data),
        .raw_channel(raw_channel), .dma_valid(dma_valid), .dma_ready(dma_ready),
        .dma_data(dma_data), .dma_addr(dma_addr));
    adcfc_core_model adcfc_core_model_i (.sys_clk(sys_clk), .rst(rst), .go(go),
        .go_data(go_data), .go_ch(go_ch), .stall(stall), .raw_valid(raw_valid),
        .raw_data(raw_data), .raw_channel(raw_channel), .dma_valid(dma_valid),
        .dma_ready(dma_ready), .dma_data(dma_data), .dma_addr(dma_addr),
        .rx_data(rx_data), .rx_addr(rx_addr), .rx_cnt(rx_cnt));
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk("register read", exp, reg_rdata);
    endtask
    task automatic conv(input logic [11:0] d, input logic [5:0] ch);
        @(posedge sys_clk);
        go <= 1'b1;
        go_data <= d;
        go_ch <= ch;
        @(posedge sys_clk);
        go <= 1'b0;
    endtask
    task automatic take(input logic [15:0] ed, input logic [15:0] ea);
        logic [7:0] n;
        n = rx_cnt;
        for (int i = 0; i < 20 && rx_cnt == n; i++) @(posedge sys_clk);
        #1;
        if (rx_cnt == n) begin
            mismatches++;
            $display("unexpected dma word count: expected %h seen %h", n + 8'h01, rx_cnt);
            end_of_test();
        end
        chk("dma data", ed, rx_data);
        chk("dma addr", ea, rx_addr);
    endtask
    // unpacking of a raw result per resolution and format code
    function automatic logic [15:0] fmt(input logic [11:0] d, input logic t, input logic [1:0] f);
        logic [15:0] i12, i10;
        i12 = f[0] ? {{5{~d[11]}}, d[10:0]} : {4'h0, d};
        i10 = f[0] ? {{7{~d[9]}}, d[8:0]} : {6'h00, d[9:0]};
        return t ? (f[1] ? {i12[11:0], 4'h0} : i12) : (f[1] ? {i10[9:0], 6'h00} : i10);
    endfunction
    initial begin
        logic [7:0] n;
        rst <= 1'b1;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        rd(ADCFC_OFF_CTRL1, ADCFC_CTRL1_RST);
        rd(4'hF, 16'h0000);
        wr(ADCFC_OFF_CTRL1, 16'h0408);
        rd(ADCFC_OFF_CTRL1, 16'h0400);
        chk("sample holds", 16'h0001, {13'h0, conv_sh_count});
        chk("resolution", 16'h0001, {15'h0, conv_12bit});
        wr(ADCFC_OFF_CTRL1, 16'h9400);
        wr(ADCFC_OFF_CTRL1, 16'h9000);
        rd(ADCFC_OFF_CTRL1, 16'h9400);
        for (int f = 0; f < 4; f++) begin
            wr(ADCFC_OFF_CTRL1, 16'h9400 | {6'h00, f[1:0], 8'h00});
            conv(12'hA53, 6'h05);
            take(fmt(12'hA53, 1'b1, f[1:0]), ADCFC_BUF_BASE + f[15:0]);
        end
        rd(ADCFC_OFF_RESULT, 16'h0004);
        $display("test twelve bit done");
        wr(ADCFC_OFF_CTRL1, 16'h0000);
        wr(ADCFC_OFF_CTRL1, 16'h1000);
        rd(ADCFC_OFF_CTRL1, 16'h1000);
        chk("sample holds", 16'h0004, {13'h0, conv_sh_count});
        for (int f = 0; f < 4; f++) begin
            wr(ADCFC_OFF_CTRL1, 16'h9000 | {6'h00, f[1:0], 8'h00});
            conv(12'h2C7, 6'h23);
            take(fmt(12'h2C7, 1'b0, f[1:0]), ADCFC_BUF_BASE + f[15:0]);
        end
        conv(12'h001, 6'h24);
        rd(ADCFC_OFF_STATUS, 16'h0012);
        $display("test ten bit done");
        wr(ADCFC_OFF_CTRL1, 16'h0000);
        wr(ADCFC_OFF_DMACFG, 16'h0002);
        rd(ADCFC_OFF_DMACFG, 16'h0002);
        wr(ADCFC_OFF_CTRL1, 16'h8000);
        for (int k = 0; k < 2; k++) begin
            conv(12'h155, 6'h23);
            take(16'h0155, ADCFC_BUF_BASE + 16'h008C + k[15:0]);
        end
        $display("test scatter done");
        wr(ADCFC_OFF_CTRL1, 16'hA000);
        device_idle <= 1'b1;
        n = rx_cnt;
        conv(12'h0AA, 6'h01);
        repeat (6) @(posedge sys_clk);
        #1 chk("halted", 16'h0000, {15'h0, conv_enable});
        chk("dma count", {8'h00, n}, {8'h00, rx_cnt});
        @(posedge sys_clk);
        device_idle <= 1'b0;
        wr(ADCFC_OFF_CTRL1, 16'h8000);
        device_idle <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 chk("running in idle", 16'h0001, {15'h0, conv_enable});
        $display("test idle done");
        n = rx_cnt;
        @(posedge sys_clk);
        stall <= 1'b1;
        go <= 1'b1;
        go_data <= 12'h0F0;
        go_ch <= 6'h00;
        repeat (12) @(posedge sys_clk);
        go <= 1'b0;
        rd(ADCFC_OFF_STATUS, 16'h000A);
        @(posedge sys_clk);
        stall <= 1'b0;
        for (int k = 0; k < 40 && dma_valid !== 1'b0; k++) @(posedge sys_clk);
        #1 chk("drained", 16'h0000, {15'h0, dma_valid});
        chk("last word", 16'h00F0, rx_data);
        chk("dma words", {8'h00, n + 8'(ADCFC_FIFO_DEPTH + 1)}, {8'h00, rx_cnt});
        chk("last addr", 16'h0002, rx_addr);
        $display("test fifo done");
        end_of_test();
    end
endmodule // adcfc_ctrl_tb
`default_nettype wire

// File: hdl/adcfc_ctrl.sv
/*
 * Digital control of a SAR converter: mode, on/off, idle halt,
 * result formatting and DMA address generation, with an 8-deep
 * result FIFO towards the DMA channel.
 * Assumes raw results arrive as one-cycle strobes with a channel index,
 * and that device idle is a level from the power controller (sys_clk domain).
 */
// The register addresses and strobed register access were decided locally.
// Behaviour
// - two setups: default 10-bit with four sample/holds, or 12-bit with one
// - in 12-bit mode simultaneous sampling of several channels never happens
// - channel selection reaches up to 36 analog inputs
// - bit 15 runs the converter when set, off when clear, resets zero
// - bit 13 set halts the converter in idle; clear keeps converting
// - bit 12 set: conversion-order buffers, DMA address equals result buffer address
// - bit 12 clear: scatter/gather address from input index and buffer size
// - bit 10 set selects 12-bit single channel; clear 10-bit four channels
// - 10-bit format codes: signed frac, frac, signed int, unsigned int
// - 12-bit data uses same codes with bit 11 sign and four zero bits
`timescale 1ns/1ps
`default_nettype none
module adcfc_ctrl
    import adcfc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // device power state
    input wire logic device_idle,
    // converter core
    output logic conv_enable,
    output logic conv_12bit,
    output logic [2:0] conv_sh_count,
    input wire logic raw_valid,
    input wire logic [11:0] raw_data,
    input wire logic [5:0] raw_channel,
    // dma channel
    output logic dma_valid,
    input wire logic dma_ready,
    output logic [15:0] dma_data,
    output logic [15:0] dma_addr
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ADCFC_OFF = 3'b001,
        ADCFC_RUN = 3'b010,
        ADCFC_HALT = 3'b100
    } adcfc_state_e;

    adcfc_state_e state_r, state_nxt;
    logic [15:0] ctrl1_r;
    logic [15:0] dmacfg_r;
    logic [15:0] rdata_r;
    logic [15:0] order_idx_r;
    logic overflow_r;
    logic drop_r;
    logic conv_enable_r;
    logic conv_12bit_r;
    logic [2:0] conv_sh_count_r;
    logic dma_valid_r;
    logic [15:0] dma_data_r;
    logic [15:0] dma_addr_r;

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    wire on_bit = ctrl1_r[ADCFC_BIT_ON];
    wire idle_halt = ctrl1_r[ADCFC_BIT_IDLE_HALT];
    wire dma_build = ctrl1_r[ADCFC_BIT_DMA_BUILD];
    wire res12 = ctrl1_r[ADCFC_BIT_RES];
    wire [1:0] form = ctrl1_r[ADCFC_BIT_FORM_HI:ADCFC_BIT_FORM_LO];
    wire [3:0] buf_words_log2 = dmacfg_r[3:0];
    wire running = (state_r == ADCFC_RUN);
    wire wr_ctrl1 = reg_wr && (reg_addr == ADCFC_OFF_CTRL1);
    wire wr_dmacfg = reg_wr && (reg_addr == ADCFC_OFF_DMACFG);
    wire rd_status = reg_rd && (reg_addr == ADCFC_OFF_STATUS);

    // ------------------------------------------------------------
    // result formatting
    // ------------------------------------------------------------
    function automatic logic [15:0] fmt_result(input logic [11:0] d, input logic is12,
                                               input logic [1:0] f);
        logic [15:0] r;
        r = 16'h0000;
        if (is12) begin
            unique case (f)
                ADCFC_FMT_SFRAC: r = {~d[11], d[10:0], 4'h0};
                ADCFC_FMT_UFRAC: r = {d[11:0], 4'h0};
                ADCFC_FMT_SINT: r = {{5{~d[11]}}, d[10:0]};
                ADCFC_FMT_UINT: r = {4'h0, d[11:0]};
            endcase
        end else begin
            unique case (f)
                ADCFC_FMT_SFRAC: r = {~d[9], d[8:0], 6'h00};
                ADCFC_FMT_UFRAC: r = {d[9:0], 6'h00};
                ADCFC_FMT_SINT: r = {{7{~d[9]}}, d[8:0]};
                ADCFC_FMT_UINT: r = {6'h00, d[9:0]};
            endcase
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // dma addressing
    // ------------------------------------------------------------
    // scatter/gather: each input owns a block of 2^size words
    function automatic logic [15:0] sg_addr(input logic [5:0] ch, input logic [3:0] lg,
                                            input logic [15:0] idx);
        logic [15:0] blk;
        logic [15:0] mask;
        blk = 16'({10'h000, ch} << lg);
        mask = 16'((16'h0001 << lg) - 16'h0001);
        return ADCFC_BUF_BASE + blk + (idx & mask);
    endfunction

    wire [15:0] result_word = fmt_result(raw_data, res12, form);
    wire ch_ok = (raw_channel < 6'(ADCFC_NUM_CH));
    wire take = running && raw_valid && ch_ok;
    wire [15:0] addr_word = dma_build ? (ADCFC_BUF_BASE + order_idx_r)
                                      : sg_addr(raw_channel, buf_words_log2, order_idx_r);

    // ------------------------------------------------------------
    // result fifo
    // ------------------------------------------------------------
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [ADCFC_FIFO_WIDTH-1:0] fifo_out_data;
    wire pop = fifo_out_valid && (!dma_valid_r || dma_ready);

    adcfc_fifo #(
        .WIDTH(ADCFC_FIFO_WIDTH),
        .DEPTH(ADCFC_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(take),
        .in_ready(fifo_in_ready),
        .in_data({addr_word, result_word}),
        .out_valid(fifo_out_valid),
        .out_ready(!dma_valid_r || dma_ready),
        .out_data(fifo_out_data)
    );
    // full address rides beside each result: scatter blocks exceed 64 words

    // ------------------------------------------------------------
    // mode state machine
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ADCFC_OFF: if (on_bit) state_nxt = ADCFC_RUN;
            ADCFC_RUN: begin
                if (!on_bit) state_nxt = ADCFC_OFF;
                else if (device_idle && idle_halt) state_nxt = ADCFC_HALT;
            end
            ADCFC_HALT: begin
                if (!on_bit) state_nxt = ADCFC_OFF;
                else if (!device_idle || !idle_halt) state_nxt = ADCFC_RUN;
            end
            default: state_nxt = ADCFC_OFF;
        endcase
    end

    // resolution only changes while off; a write that tries otherwise keeps it
    wire res_locked = on_bit;
    wire [15:0] ctrl1_w = reg_wdata & ADCFC_CTRL1_WMASK;
    wire [15:0] ctrl1_guard = res_locked
        ? {ctrl1_w[15:11], ctrl1_r[ADCFC_BIT_RES], ctrl1_w[9:0]} : ctrl1_w;
    // no simultaneous sampling in 12-bit mode
    wire [15:0] ctrl1_nxt = ctrl1_guard[ADCFC_BIT_RES]
        ? (ctrl1_guard & ~(16'h0001 << ADCFC_BIT_SIMSAM)) : ctrl1_guard;

    wire [15:0] status_word = {11'h000, drop_r, overflow_r, state_r};
    wire [15:0] rdata_nxt =
        (reg_addr == ADCFC_OFF_CTRL1) ? ctrl1_r :
        (reg_addr == ADCFC_OFF_DMACFG) ? dmacfg_r :
        (reg_addr == ADCFC_OFF_STATUS) ? status_word :
        (reg_addr == ADCFC_OFF_RESULT) ? order_idx_r : 16'h0000;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= ADCFC_OFF;
            ctrl1_r <= ADCFC_CTRL1_RST;
            dmacfg_r <= ADCFC_DMACFG_RST;
        end else begin
            state_r <= state_nxt;
            if (wr_ctrl1) ctrl1_r <= ctrl1_nxt;
            if (wr_dmacfg) dmacfg_r <= {12'h000, reg_wdata[3:0]};
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= reg_rd ? rdata_nxt : 16'h0000;
        end
    end

    // conversion-order index restarts whenever the converter is off
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            order_idx_r <= 16'h0000;
            overflow_r <= 1'b0;
            drop_r <= 1'b0;
        end else begin
            if (!on_bit) order_idx_r <= 16'h0000;
            else if (take && fifo_in_ready) order_idx_r <= order_idx_r + 16'h0001;
            // set wins over a clear in the same cycle
            overflow_r <= (take && !fifo_in_ready) || (overflow_r && !rd_status);
            drop_r <= (running && raw_valid && !ch_ok) || (drop_r && !rd_status);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            conv_enable_r <= 1'b0;
            conv_12bit_r <= 1'b0;
            conv_sh_count_r <= 3'h0;
        end else begin
            conv_enable_r <= (state_nxt == ADCFC_RUN);
            conv_12bit_r <= res12;
            conv_sh_count_r <= res12 ? 3'h1 : 3'(ADCFC_NUM_SH_10B);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dma_valid_r <= 1'b0;
            dma_data_r <= 16'h0000;
            dma_addr_r <= 16'h0000;
        end else begin
            if (pop) begin
                dma_valid_r <= 1'b1;
                dma_data_r <= fifo_out_data[15:0];
                dma_addr_r <= fifo_out_data[31:16];
            end else if (dma_ready) begin
                dma_valid_r <= 1'b0;
            end
        end
    end

    assign reg_rdata = rdata_r;
    assign conv_enable = conv_enable_r;
    assign conv_12bit = conv_12bit_r;
    assign conv_sh_count = conv_sh_count_r;
    assign dma_valid = dma_valid_r;
    assign dma_data = dma_data_r;
    assign dma_addr = dma_addr_r;
endmodule // adcfc_ctrl
`default_nettype wire

// File: hdl/adcfc_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes a single clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module adcfc_fifo #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data = mem_r[rd_ptr_r];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + AW'(1);
            if (pop) rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + AW'(1);
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // storage has no reset: contents are only read behind out_valid
    always_ff @(posedge sys_clk) begin
        if (push) mem_r[wr_ptr_r] <= in_data;
    end
endmodule // adcfc_fifo
`default_nettype wire

// File: hdl/adcfc_pkg.sv
/*
 * Package for the converter mode and format control block: register
 * offsets, field positions, reset values and format codes.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package adcfc_pkg;
    // ------------------------------------------------------------
    // register map (indexes on the plain register port)
    // ------------------------------------------------------------
    localparam logic [3:0] ADCFC_OFF_CTRL1 = 4'h0;
    localparam logic [3:0] ADCFC_OFF_DMACFG = 4'h1;
    localparam logic [3:0] ADCFC_OFF_STATUS = 4'h2;
    localparam logic [3:0] ADCFC_OFF_RESULT = 4'h3;
    // ------------------------------------------------------------
    // control register 1 fields
    // ------------------------------------------------------------
    localparam int ADCFC_BIT_ON = 15;
    localparam int ADCFC_BIT_IDLE_HALT = 13;
    localparam int ADCFC_BIT_DMA_BUILD = 12;
    localparam int ADCFC_BIT_RES = 10;
    localparam int ADCFC_BIT_FORM_HI = 9;
    localparam int ADCFC_BIT_FORM_LO = 8;
    localparam int ADCFC_BIT_SIMSAM = 3;
    localparam logic [15:0] ADCFC_CTRL1_RST = 16'h0000;
    localparam logic [15:0] ADCFC_CTRL1_WMASK = 16'hB70F;
    localparam logic [15:0] ADCFC_DMACFG_RST = 16'h0000;
    // ------------------------------------------------------------
    // format codes and sizes
    // ------------------------------------------------------------
    localparam logic [1:0] ADCFC_FMT_UINT = 2'h0;
    localparam logic [1:0] ADCFC_FMT_SINT = 2'h1;
    localparam logic [1:0] ADCFC_FMT_UFRAC = 2'h2;
    localparam logic [1:0] ADCFC_FMT_SFRAC = 2'h3;
    localparam int ADCFC_NUM_CH = 36;
    localparam int ADCFC_NUM_SH_10B = 4;
    localparam int ADCFC_FIFO_DEPTH = 8;
    localparam int ADCFC_FIFO_WIDTH = 32;
    localparam logic [15:0] ADCFC_BUF_BASE = 16'h0000;
endpackage
